// ===== design/timer8_pkg.sv
package timer8_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FORCE = 5'h04;
  localparam logic [4:0] OFF_COUNT = 5'h08;
  localparam logic [4:0] OFF_CMP_A = 5'h0C;
  localparam logic [4:0] OFF_CMP_B = 5'h10;
  localparam logic [4:0] OFF_FLAGS = 5'h14;
  localparam logic [4:0] OFF_PORT = 5'h18;
  localparam logic [4:0] OFF_STATE = 5'h1C;
  // field positions in the flags and port words
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int PORT_VAL_LSB = 0;
  localparam int PORT_DIR_LSB = 4;
  // waveform mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  // output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_PSC = 10'h000;
  // prescaler masks per clock select: stop, 1, 8, 32, 64, 128, 256, 1024
  localparam logic [9:0] PSC_MASK [0:7] = '{10'h000, 10'h000, 10'h007, 10'h01F,
                                            10'h03F, 10'h07F, 10'h0FF, 10'h3FF};

  // control word layout, reserved bits held at zero
  typedef struct packed {
    logic [1:0] output_action_sel_b;
    logic [1:0] output_action_sel_a;
    logic rsv7;
    logic [2:0] clock_sel;
    logic rsv3;
    logic [2:0] waveform_mode_sel;
  } ctrl_t;
  localparam ctrl_t RST_CTRL = '0;
endpackage

// ===== design/timer8_compare_waveform_unit.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// RULE1: a counter write blocks every compare match during the next timer tick
// RULE2: output state keeps its value across waveform mode changes
// RULE3: action select changes govern the very next compare match
// RULE4: nonzero action select replaces the port value on the pin
// RULE5: pin shows the output only while its direction bit selects output
// RULE6: action select zero leaves the output state untouched on matches
// RULE7: force strobe applies the action at once in non-PWM modes
// RULE8: normal mode increments and wraps from FF to 00
// RULE9: normal mode sets overflow flag when the counter becomes zero
// RULE10: clear-on-compare mode resets counter when it equals compare A
// RULE11: compare A unbuffered there; below count means wrap before match
// RULE12: toggle action in clear-on-compare toggles output each match
// RULE13: clear-on-compare sets overflow flag on the MAX to 00 step
// RULE14: modes 3 and 7 are fast PWM with top FF or compare A
// RULE15: fast PWM counts up to top then clears on next tick
// RULE16: fast PWM sets overflow flag each time counter reaches top
// RULE17: fast PWM action 2 clears on match sets at bottom, 3 inverse
// RULE18: compare MAX gives constant level, zero gives one-tick spike
// RULE19: fast PWM toggle action gives square wave with buffering kept
// RULE20: compare values are double buffered while fast PWM is active
// RULE21: tick is clock divided by 1, 8, 32, 64, 128, 256 or 1024
// RULE22: a match sets its compare flag; writing one clears it
// RULE23: forced compare only updates output, no flag, no counter change
// RULE24: software counter write beats any clear or count that cycle
// RULE25: buffered compare values load when counter wraps top to bottom
module timer8_compare_waveform_unit #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // compare pins, index 0 is channel a
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe
);

  // bus state
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  // timer state
  timer8_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic [9:0] psc_reg, psc_next;
  logic [7:0] counter_value_reg, counter_value_next;
  logic [7:0] cmp_buf_reg [2];
  logic [7:0] cmp_buf_next [2];
  logic [7:0] cmp_act_reg [2];
  logic [7:0] cmp_act_next [2];
  logic [1:0] compare_output_state_reg, compare_output_state_next;
  logic [2:0] flags_reg, flags_next;
  logic [1:0] port_val_reg, port_val_next;
  logic [1:0] pin_dir_reg, pin_dir_next;
  logic block_reg, block_next;
  logic [1:0] pin_out_reg, pin_out_next;
  logic [1:0] pin_oe_reg, pin_oe_next;

  // decode and strobes
  logic mapped, wr_fire, setup;
  logic [4:0] offs;
  logic cnt_wr, ctrl_wr, force_wr, flags_wr;
  logic tick, pwm_mode, at_top, wrap, ctc_clear, ovf_set;
  logic [7:0] top_val;
  logic [1:0] match_v, force_v, eq_v;
  logic [1:0] act_sel [2];

  // registered answer one cycle after setup, so pready is a flop
  assign setup = psel && !penable;
  assign offs = paddr[4:0];
  assign mapped = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'h0);
  assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign cnt_wr = wr_fire && (offs == timer8_pkg::OFF_COUNT);
  assign ctrl_wr = wr_fire && (offs == timer8_pkg::OFF_CTRL);
  assign force_wr = wr_fire && (offs == timer8_pkg::OFF_FORCE);
  assign flags_wr = wr_fire && (offs == timer8_pkg::OFF_FLAGS);

  // read mux and ready; data is sampled at setup
  always_comb begin
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = 32'h0000_0000;
    if (setup && mapped && !pwrite) begin
      unique case (offs)
        timer8_pkg::OFF_CTRL: prdata_next = {20'h0_0000, ctrl_reg};
        timer8_pkg::OFF_COUNT: prdata_next = {24'h00_0000, counter_value_reg};
        timer8_pkg::OFF_CMP_A: prdata_next = {24'h00_0000, cmp_buf_reg[0]};
        timer8_pkg::OFF_CMP_B: prdata_next = {24'h00_0000, cmp_buf_reg[1]};
        timer8_pkg::OFF_FLAGS: prdata_next = {29'h0000_0000, flags_reg};
        timer8_pkg::OFF_PORT: prdata_next = {26'h000_0000, pin_dir_reg, 2'h0, port_val_reg};
        timer8_pkg::OFF_STATE: prdata_next = {30'h0000_0000, compare_output_state_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // tick, mode and comparator decode
  always_comb begin
    tick = (ctrl_reg.clock_sel != 3'h0) &&
           ((psc_reg & timer8_pkg::PSC_MASK[ctrl_reg.clock_sel]) ==
            timer8_pkg::PSC_MASK[ctrl_reg.clock_sel]); // RULE21
    pwm_mode = (ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_MAX) ||
               (ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_CMP); // RULE14
    top_val = (ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_CMP) ?
              cmp_act_reg[0] : timer8_pkg::CNT_MAX; // RULE14
    at_top = (counter_value_reg == top_val);
    act_sel[0] = ctrl_reg.output_action_sel_a;
    act_sel[1] = ctrl_reg.output_action_sel_b;
    for (int i = 0; i < 2; i++) begin
      eq_v[i] = (counter_value_reg == cmp_act_reg[i]);
      match_v[i] = tick && eq_v[i] && !block_reg; // RULE1
      force_v[i] = force_wr && pwdata[i] && !pwm_mode; // RULE7
    end
    // clear on compare follows the compare-a match, so a write blocks it too
    ctc_clear = (ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_CTC) && match_v[0]; // RULE10
    wrap = pwm_mode && tick && at_top; // RULE15
    // a clear from MAX still passes MAX to 00, so it counts as an overflow too
    ovf_set = pwm_mode ? wrap : // RULE16
              (tick && (counter_value_reg == timer8_pkg::CNT_MAX)); // RULE9 RULE13
  end

  // next state of counter, compare registers, outputs and flags
  always_comb begin
    ctrl_next = ctrl_reg;
    psc_next = psc_reg + 10'h001;
    counter_value_next = counter_value_reg;
    compare_output_state_next = compare_output_state_reg;
    port_val_next = port_val_reg;
    pin_dir_next = pin_dir_reg;
    block_next = tick ? 1'b0 : block_reg;
    flags_next = flags_reg;
    // counting: normal and fallback modes simply increment and wrap
    if (ctc_clear || wrap) begin
      counter_value_next = timer8_pkg::CNT_BOTTOM; // RULE10 RULE15
    end else if (tick) begin
      counter_value_next = counter_value_reg + 8'h01; // RULE8 RULE11
    end
    // software write wins over count and clear, and arms the block
    if (cnt_wr) begin
      counter_value_next = pwdata[7:0]; // RULE24
      block_next = 1'b1; // RULE1
    end
    if (ctrl_wr) begin
      ctrl_next = pwdata[11:0]; // RULE3
      ctrl_next.rsv7 = 1'b0;
      ctrl_next.rsv3 = 1'b0;
    end
    if (wr_fire && (offs == timer8_pkg::OFF_PORT)) begin
      port_val_next = pwdata[timer8_pkg::PORT_VAL_LSB +: 2];
      pin_dir_next = pwdata[timer8_pkg::PORT_DIR_LSB +: 2];
    end
    // flags: software clear by writing one, a same-cycle set wins
    if (flags_wr) begin
      flags_next = flags_reg & ~pwdata[2:0]; // RULE22
    end
    if (ovf_set) begin
      flags_next[timer8_pkg::FLAG_OVF] = 1'b1; // RULE9 RULE13 RULE16
    end
    for (int i = 0; i < 2; i++) begin
      cmp_buf_next[i] = cmp_buf_reg[i];
      if (wr_fire && (offs == (i == 0 ? timer8_pkg::OFF_CMP_A : timer8_pkg::OFF_CMP_B))) begin
        cmp_buf_next[i] = pwdata[7:0];
      end
      // outside fast PWM writes reach the comparator at once
      cmp_act_next[i] = pwm_mode ? (wrap ? cmp_buf_reg[i] : cmp_act_reg[i]) // RULE20 RULE25
                                 : cmp_buf_next[i]; // RULE11
      if (match_v[i]) begin
        flags_next[i + 1] = 1'b1; // RULE22
      end
      // output action; force touches only the output state
      if ((match_v[i] || force_v[i]) && (act_sel[i] != timer8_pkg::ACT_NONE)) begin // RULE6 RULE23
        unique case (act_sel[i])
          timer8_pkg::ACT_TOGGLE:
            compare_output_state_next[i] = !compare_output_state_reg[i]; // RULE12 RULE19
          timer8_pkg::ACT_CLEAR: compare_output_state_next[i] = 1'b0; // RULE17
          timer8_pkg::ACT_SET: compare_output_state_next[i] = 1'b1; // RULE17
          default: compare_output_state_next[i] = compare_output_state_reg[i];
        endcase
      end
      // bottom action after the match, so compare MAX stays constant
      if (wrap && (act_sel[i] == timer8_pkg::ACT_CLEAR)) begin
        compare_output_state_next[i] = 1'b1; // RULE17 RULE18
      end else if (wrap && (act_sel[i] == timer8_pkg::ACT_SET)) begin
        compare_output_state_next[i] = 1'b0; // RULE17 RULE18
      end
      // pin override and direction; state can be set up before enabling
      pin_out_next[i] = (act_sel[i] != timer8_pkg::ACT_NONE) ?
                        compare_output_state_reg[i] : port_val_reg[i]; // RULE4
      pin_oe_next[i] = pin_dir_reg[i]; // RULE5
    end
  end

  // mode switches never write the output state, so it survives them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= timer8_pkg::RST_CTRL;
      psc_reg <= timer8_pkg::RST_PSC;
      counter_value_reg <= timer8_pkg::RST_BYTE;
      cmp_buf_reg[0] <= timer8_pkg::RST_BYTE;
      cmp_buf_reg[1] <= timer8_pkg::RST_BYTE;
      cmp_act_reg[0] <= timer8_pkg::RST_BYTE;
      cmp_act_reg[1] <= timer8_pkg::RST_BYTE;
      compare_output_state_reg <= 2'h0;
      flags_reg <= 3'h0;
      port_val_reg <= 2'h0;
      pin_dir_reg <= 2'h0;
      block_reg <= 1'b0;
      pin_out_reg <= 2'h0;
      pin_oe_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      psc_reg <= psc_next;
      counter_value_reg <= counter_value_next;
      cmp_buf_reg <= cmp_buf_next;
      cmp_act_reg <= cmp_act_next;
      compare_output_state_reg <= compare_output_state_next; // RULE2
      flags_reg <= flags_next;
      port_val_reg <= port_val_next;
      pin_dir_reg <= pin_dir_next;
      block_reg <= block_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cmp_pin_out = pin_out_reg;
  assign cmp_pin_oe = pin_oe_reg;

  // checks
  chk_write_blocks_match: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    cnt_wr ##1 tick |-> match_v == 2'h0)
    else $error("compare match not blocked after counter write");

  chk_mode_keeps_state: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    ctrl_wr && !tick && !force_wr |=> $stable(compare_output_state_reg))
    else $error("output state changed on mode write");

  // pin source and direction follow their registers one cycle later
  chk_pin_override: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ##1 cmp_pin_out[0] == ($past(act_sel[0] != 2'h0) ?
        $past(compare_output_state_reg[0]) : $past(port_val_reg[0])))
    else $error("pin a shows wrong source");

  chk_pin_direction: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ##1 cmp_pin_oe == $past(pin_dir_reg))
    else $error("pin enable does not follow direction");

  chk_off_no_change: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    act_sel[1] == 2'h0 |=> $stable(compare_output_state_reg[1]))
    else $error("output b changed with action none");

  chk_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    tick && ctrl_reg.waveform_mode_sel == 3'h0 && counter_value_reg == 8'hFF && !cnt_wr
    |=> counter_value_reg == 8'h00 && flags_reg[0])
    else $error("normal mode wrap or overflow wrong");

  chk_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    ctc_clear && !cnt_wr |=> counter_value_reg == 8'h00 && flags_reg[1])
    else $error("clear on compare failed");

  chk_force_no_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    force_wr && !tick |=> $stable(counter_value_reg) && $stable(flags_reg))
    else $error("force touched counter or flags");

  chk_pwm_bottom_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    wrap && act_sel[0] == 2'h2 |=> compare_output_state_reg[0])
    else $error("non-inverting output not set at bottom");

  chk_buffer_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    pwm_mode && !wrap |=> $stable(cmp_act_reg[0]) && $stable(cmp_act_reg[1]))
    else $error("active compare changed mid period");

  chk_write_priority: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
    cnt_wr |=> counter_value_reg == $past(pwdata[7:0]) ##1 !$past(tick) || block_reg == 1'b0)
    else $error("counter write lost");

  // flags: a match sets its flag at the edge ending the tick, and set beats clear
  chk_match_flag_a: assert property ( // RULE22
    @(posedge pclk) disable iff (!presetn)
    match_v[0] |=> flags_reg[timer8_pkg::FLAG_CMP_A])
    else $error("compare flag a not set on match");

  chk_match_flag_b: assert property ( // RULE22
    @(posedge pclk) disable iff (!presetn)
    match_v[1] |=> flags_reg[timer8_pkg::FLAG_CMP_B])
    else $error("compare flag b not set on match");

  chk_flag_sw_clear: assert property ( // RULE22
    @(posedge pclk) disable iff (!presetn)
    flags_wr && pwdata[1] && !match_v[0] |=> !flags_reg[timer8_pkg::FLAG_CMP_A])
    else $error("compare flag a not cleared by write");

  // counting and overflow in each mode
  chk_normal_increment: assert property ( // RULE8
    @(posedge pclk) disable iff (!presetn)
    tick && ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_NORMAL && !cnt_wr
    |=> counter_value_reg == $past(counter_value_reg) + 8'h01)
    else $error("normal mode did not increment");

  chk_ctc_overflow: assert property ( // RULE13
    @(posedge pclk) disable iff (!presetn)
    tick && ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_CTC && counter_value_reg == 8'hFF
    |=> flags_reg[timer8_pkg::FLAG_OVF])
    else $error("clear on compare missed overflow");

  chk_pwm_wrap_zero: assert property ( // RULE15
    @(posedge pclk) disable iff (!presetn)
    wrap && !cnt_wr |=> counter_value_reg == 8'h00)
    else $error("fast pwm did not clear after top");

  chk_pwm_overflow: assert property ( // RULE16
    @(posedge pclk) disable iff (!presetn)
    wrap |=> flags_reg[timer8_pkg::FLAG_OVF])
    else $error("fast pwm missed overflow at top");

  chk_top_at_cmp: assert property ( // RULE14
    @(posedge pclk) disable iff (!presetn)
    tick && ctrl_reg.waveform_mode_sel == timer8_pkg::MODE_FAST_CMP &&
    counter_value_reg == cmp_act_reg[0] && !cnt_wr |=> counter_value_reg == 8'h00)
    else $error("fast pwm top is not compare a");

  // output actions and forced compares
  chk_toggle_match: assert property ( // RULE12 RULE19
    @(posedge pclk) disable iff (!presetn)
    match_v[0] && act_sel[0] == 2'h1 |=> compare_output_state_reg[0] != $past(compare_output_state_reg[0]))
    else $error("toggle action did not toggle");

  chk_force_sets: assert property ( // RULE7
    @(posedge pclk) disable iff (!presetn)
    force_wr && pwdata[0] && !pwm_mode && act_sel[0] == 2'h3 |=> compare_output_state_reg[0])
    else $error("forced set action not applied");

  chk_pwm_bottom_clear: assert property ( // RULE17
    @(posedge pclk) disable iff (!presetn)
    wrap && act_sel[0] == 2'h3 |=> !compare_output_state_reg[0])
    else $error("inverting output not cleared at bottom");

  // compare loading and tick rate
  chk_cmp_unbuffered: assert property ( // RULE11
    @(posedge pclk) disable iff (!presetn)
    wr_fire && offs == timer8_pkg::OFF_CMP_A && !pwm_mode
    |=> cmp_act_reg[0] == $past(pwdata[7:0]))
    else $error("compare a not written through");

  chk_buffer_load: assert property ( // RULE25
    @(posedge pclk) disable iff (!presetn)
    wrap |=> cmp_act_reg[0] == $past(cmp_buf_reg[0]))
    else $error("buffered compare not loaded at wrap");

  chk_tick_period: assert property ( // RULE21
    @(posedge pclk) disable iff (!presetn)
    tick && ctrl_reg.clock_sel == 3'h2 |-> ##8 (tick || ctrl_reg.clock_sel != 3'h2))
    else $error("divide by eight tick period wrong");

endmodule

// ===== testbench/pin_load_model.sv
`timescale 1ns/1ps
// external load on the two compare pins
module pin_load_model (
  // clock
  input wire logic pclk,
  // pins from the device
  input wire logic [1:0] cmp_pin_out,
  input wire logic [1:0] cmp_pin_oe,
  // level seen at the load
  output logic [1:0] pin_level
);
  logic [1:0] float_q = 2'h0;
  // a released pin wanders every cycle so stale drive is never mistaken for drive
  always_ff @(posedge pclk) begin
    float_q <= ~float_q;
  end
  // the load follows the device only while its driver is enabled
  assign pin_level = (cmp_pin_oe & cmp_pin_out) | (~cmp_pin_oe & float_q);
endmodule

// ===== testbench/timer8_compare_waveform_unit_tb_top.sv
`timescale 1ns/1ps
module timer8_compare_waveform_unit_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cmp_pin_out;
  logic [1:0] cmp_pin_oe;
  logic [1:0] pin_level;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int comparisons = 0;
  int c, k, x, m, hi;
  int psc [0:7] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] acts [0:3] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic exp_st [0:3] = '{1'b1, 1'b0, 1'b1, 1'b1};
  // free-running bench clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  timer8_compare_waveform_unit #(.ADDR_W(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe)
  );
  pin_load_model i_load (
    .pclk(pclk), .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .pin_level(pin_level)
  );
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one apb transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] o, input logic [31:0] d);
    apb(1'b1, {7'h00, o}, d);
  endtask
  task automatic rd(input logic [4:0] o);
    apb(1'b0, {7'h00, o}, 32'h00000000);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] md, input logic [2:0] cs,
                                      input logic [1:0] aa);
    timer8_pkg::ctrl_t t;
    t = timer8_pkg::RST_CTRL;
    t.waveform_mode_sel = md;
    t.clock_sel = cs;
    t.output_action_sel_a = aa;
    return {20'h00000, t};
  endfunction
  // exactly k cycles of clock selection cs between the two control writes
  task automatic run(input logic [2:0] md, input logic [2:0] cs, input logic [1:0] aa,
                     input int k);
    wr(timer8_pkg::OFF_CTRL, ctl(md, cs, aa));
    repeat (k - 3) @(posedge pclk);
    wr(timer8_pkg::OFF_CTRL, ctl(md, 3'h0, aa));
  endtask
  // first tick after the count write cannot match, so values c+1 .. c+k-1 can
  function automatic logic [31:0] exp_flags(input int c, input int k, input int a,
                                            input int b);
    logic [31:0] f;
    f = 32'h00000000;
    f[timer8_pkg::FLAG_OVF] = (c + k) > 255;
    f[timer8_pkg::FLAG_CMP_A] = ((a - c) & 255) inside {[1:k-1]};
    f[timer8_pkg::FLAG_CMP_B] = ((b - c) & 255) inside {[1:k-1]};
    return f;
  endfunction
  // duty of pin a over n cycles
  task automatic duty(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge pclk);
      if (pin_level[0] === 1'b1) hi++;
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(94));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h00000000);
      chk("reset value", q, 32'h00000000);
    end
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk("unmapped error", 32'(e), 32'h00000001);
    wr(timer8_pkg::OFF_CTRL, 32'hFFFFFFFF);
    rd(timer8_pkg::OFF_CTRL);
    chk("control fields", q, 32'h00000F77);
    // stop the timer again so later counts start from a known point
    wr(timer8_pkg::OFF_CTRL, 32'h00000000);
    // normal mode counting, wrap, flags and match blocking, random and corner
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 254 : $urandom_range(255);
      x = (i == 0) ? 254 : $urandom_range(255);
      m = $urandom_range(255);
      k = $urandom_range(60, 3);
      wr(timer8_pkg::OFF_CMP_A, 32'(x));
      wr(timer8_pkg::OFF_CMP_B, 32'(m));
      wr(timer8_pkg::OFF_COUNT, 32'(c));
      wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
      run(timer8_pkg::MODE_NORMAL, 3'h1, timer8_pkg::ACT_NONE, k);
      rd(timer8_pkg::OFF_COUNT);
      chk("count", q, 32'((c + k) % 256));
      rd(timer8_pkg::OFF_FLAGS);
      chk("flags", q, exp_flags(c, k, x, m));
    end
    // a count write in a tick cycle wins over the increment
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_NORMAL, 3'h1, timer8_pkg::ACT_NONE));
    wr(timer8_pkg::OFF_COUNT, 32'h00000010);
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_NORMAL, 3'h0, timer8_pkg::ACT_NONE));
    rd(timer8_pkg::OFF_COUNT);
    chk("count after write", q, 32'h00000013);
    // clear on compare with compare zero: first tick blocked, then no further match
    wr(timer8_pkg::OFF_CMP_A, 32'h00000000);
    wr(timer8_pkg::OFF_COUNT, 32'h00000000);
    wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
    run(timer8_pkg::MODE_CTC, 3'h1, timer8_pkg::ACT_NONE, 3);
    rd(timer8_pkg::OFF_COUNT);
    chk("blocked clear", q, 32'h00000003);
    // toggle on each clear, period of four ticks
    wr(timer8_pkg::OFF_CMP_A, 32'h00000003);
    wr(timer8_pkg::OFF_COUNT, 32'h00000000);
    rd(timer8_pkg::OFF_STATE);
    x = int'(q[0]);
    k = $urandom_range(40, 8);
    run(timer8_pkg::MODE_CTC, 3'h1, timer8_pkg::ACT_TOGGLE, k);
    rd(timer8_pkg::OFF_COUNT);
    chk("ctc count", q, 32'(k % 4));
    rd(timer8_pkg::OFF_STATE);
    chk("ctc toggle", 32'(q[0]), 32'(x ^ ((k / 4) & 1)));
    // compare below count: wrap through 00 before clearing
    wr(timer8_pkg::OFF_CMP_A, 32'h00000005);
    wr(timer8_pkg::OFF_COUNT, 32'h000000FD);
    wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
    run(timer8_pkg::MODE_CTC, 3'h1, timer8_pkg::ACT_NONE, 10);
    rd(timer8_pkg::OFF_COUNT);
    chk("late clear", q, 32'h00000001);
    rd(timer8_pkg::OFF_FLAGS);
    chk("ctc flags", q & 32'h00000003, 32'h00000003);
    // forced compare with every action code
    wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
    wr(timer8_pkg::OFF_COUNT, 32'h00000040);
    for (int i = 0; i < 4; i++) begin
      wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_NORMAL, 3'h0, acts[i]));
      wr(timer8_pkg::OFF_FORCE, 32'h00000001);
      rd(timer8_pkg::OFF_STATE);
      chk("forced state", 32'(q[0]), 32'(exp_st[i]));
    end
    rd(timer8_pkg::OFF_FLAGS);
    chk("force flags", q, 32'h00000000);
    rd(timer8_pkg::OFF_COUNT);
    chk("force count", q, 32'h00000040);
    // mode change keeps the state; force is ignored in fast pwm
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_FAST_MAX, 3'h0, timer8_pkg::ACT_CLEAR));
    wr(timer8_pkg::OFF_FORCE, 32'h00000001);
    rd(timer8_pkg::OFF_STATE);
    chk("state kept", 32'(q[0]), 32'h00000001);
    // pin override and direction; state is set before the pin turns output
    wr(timer8_pkg::OFF_PORT, 32'h00000000);
    repeat (3) @(posedge pclk);
    chk("pin released", 32'(cmp_pin_oe), 32'h00000000);
    // channel b has no action, so its pin shows its port value
    wr(timer8_pkg::OFF_PORT, 32'h00000032);
    repeat (3) @(negedge pclk);
    chk("pin shows state", 32'(pin_level), 32'h00000003);
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_FAST_MAX, 3'h0, timer8_pkg::ACT_NONE));
    repeat (3) @(negedge pclk);
    chk("pin shows port", 32'(pin_level), 32'h00000002);
    // fast pwm duty for both polarities, extremes and a random compare
    for (int p = 0; p < 2; p++) begin
      wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_FAST_MAX, 3'h1, acts[p]));
      for (int i = 0; i < 3; i++) begin
        x = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(254, 1);
        wr(timer8_pkg::OFF_CMP_A, 32'(x));
        repeat (300) @(posedge pclk);
        duty(256);
        chk("pwm duty", 32'(hi), 32'((p == 1) ? x + 1 : 255 - x));
      end
    end
    // fast pwm with top at compare a and toggle: square wave of period 20
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_NORMAL, 3'h0, timer8_pkg::ACT_NONE));
    wr(timer8_pkg::OFF_CMP_A, 32'h00000009);
    wr(timer8_pkg::OFF_FLAGS, 32'h00000007);
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_FAST_CMP, 3'h1, timer8_pkg::ACT_TOGGLE));
    repeat (300) @(posedge pclk);
    duty(200);
    chk("square wave", 32'(hi), 32'h00000064);
    rd(timer8_pkg::OFF_COUNT);
    chk("below top", 32'(q <= 32'h00000009), 32'h00000001);
    rd(timer8_pkg::OFF_FLAGS);
    chk("pwm overflow", 32'(q[timer8_pkg::FLAG_OVF]), 32'h00000001);
    // every prescale factor gives four ticks in four periods; stop the pwm run first
    wr(timer8_pkg::OFF_CTRL, ctl(timer8_pkg::MODE_NORMAL, 3'h0, timer8_pkg::ACT_NONE));
    for (int s = 1; s < 8; s++) begin
      wr(timer8_pkg::OFF_COUNT, 32'h00000000);
      run(timer8_pkg::MODE_NORMAL, 3'(s), timer8_pkg::ACT_NONE, 4 * psc[s]);
      rd(timer8_pkg::OFF_COUNT);
      chk("prescaled count", q, 32'h00000004);
    end
    end_sim();
  end
  // watchdog well beyond the expected run of about 11000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
endmodule
